// [rtl/irc_carrier_gen.sv]
/*
 * Carrier divider: main clock divided by 64 or 96 with a coded high time.
 * Assumes run, divide select and duty code are stable while run is high.
 */
`timescale 1ns/10ps
`include "irc_regs.svh"

module irc_carrier_gen (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       divSel,
    input  wire logic [3:0] duty,
    output logic            carrierWave,
    output logic            periodEnd
);
    irc_pkg::irc_carrier_state_t s_reg, s_next;
    logic [6:0] lastCnt;
    logic [6:0] highCnt;
    logic [3:0] duty64;

    always_comb begin
        lastCnt = divSel ? `IRC_DIV96_LAST : `IRC_DIV64_LAST;
        duty64  = (duty > `IRC_DUTY64_MAX) ? `IRC_DUTY64_MAX : duty;
        if (divSel) begin
            // Codes 1100 and above give no high time at all
            highCnt = (duty < `IRC_DUTY96_LIMIT) ?
                      7'((7'(duty) + 7'h01) << 2) : 7'h00;
        end else begin
            highCnt = 7'((7'(duty64) + 7'h01) << 3);
        end
        s_next = s_reg;
        s_next.periodEnd = 1'b0;
        if (!run) begin
            s_next.cnt  = 7'h00;
            s_next.wave = 1'b0;
        end else begin
            if (s_reg.cnt == lastCnt) begin
                s_next.cnt = 7'h00;
            end else begin
                s_next.cnt = s_reg.cnt + 7'h01;
            end
            // Marked two clocks early: tau and the width gate add a register
            // each, so the gate opens and shuts on whole carrier cycles
            s_next.periodEnd = (s_next.cnt == lastCnt - 7'h01);
            s_next.wave      = (s_next.cnt < highCnt);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign carrierWave = s_reg.wave;
    assign periodEnd   = s_reg.periodEnd;

endmodule : irc_carrier_gen

// [rtl/irc_carrier_top.sv]
/*
 * Infrared carrier generator: APB register file, run control, hard-timer
 * width and interrupt counters, soft-timer forced output, interrupt request.
 * Assumes one 10 MHz clock used as the main oscillator, a synchronous
 * reset, an APB master and a CPU mask level on the same clock.
 */
`timescale 1ns/10ps
`include "irc_regs.svh"

// What this block does
// - Divide select picks carrier = clock/96 when set, /64 when clear; reset /64.
// - At /96, duty n gives (n+1)/24 high; codes 1100 up give no carrier.
// - At /64, duty 0..3 gives (n+1)/8 high; higher codes act as 3; resets 0.
// - Tau select divides carrier by 32, 20, 16, 12; reset selects 12.
// - Generation enable turns circuit on/off, reads back, resets to one.
// - Forced bit drives carrier to pin while enabled, else pin low; resets 0.
// - Width write 0..3 outputs carrier that many taus from next tau rise.
// - Width setting clears at reset and whenever generation is disabled.
// - Count write 0..14 while enabled counts tau rises, then sets the flag.
// - Count field write-only, reads zero; counter idles at 0xF, once per write.
// - Flag sets on completion regardless of enable; write one clears it.
// - Request reaches CPU only if flag, enable and priority above mask.
// - Priority codes give levels 3..0, level 0 means none; reset 0.
// - Enable starts set for initialisation; clearing allowed after 32 cycles.
// - Clearing enable stops the circuit at the next tau boundary.
// - Tau generator runs continuously while generation is enabled.
module irc_carrier_top (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  cpuMaskLevel,
    output logic             carrierOutputPin,
    output logic             irqRequest
);

    ////////////////////////////////////////////////////////////////////////
    // State and sub-blocks

    localparam irc_pkg::irc_main_state_t RESET_STATE = '{
        run:          irc_pkg::RUN_ON,
        genEnable:    `IRC_RST_GENEN,
        irqEn:        `IRC_RST_IRQEN,
        prio:         `IRC_RST_PRIO,
        flag:         1'b0,
        forced:       1'b0,
        tauSel:       `IRC_RST_TAU,
        divSel:       `IRC_RST_DIV,
        duty:         `IRC_RST_DUTY,
        icTarget:     `IRC_IC_IDLE,
        icPending:    1'b0,
        icCount:      `IRC_IC_IDLE,
        width:        `IRC_RST_WIDTH,
        widthPending: 1'b0,
        widthLeft:    2'h0,
        initCnt:      6'h00,
        rdata:        8'h00,
        ready:        1'b0,
        slvErr:       1'b0,
        carrierOut:   1'b0,
        irqReq:       1'b0
    };

    irc_pkg::irc_main_state_t s_reg, s_next;

    logic       running;
    logic       carrierWave;
    logic       periodEnd;
    logic       tauRise;
    logic [15:0] regIdx;
    logic       hitPrio;
    logic       hitEnable;
    logic       hitFlag;
    logic       hitConfig;
    logic       hitCount;
    logic       hitWidth;
    logic       mapped;
    logic       wrDone;
    logic [7:0] wd;
    logic [7:0] rdMux;
    logic       icDone;
    logic       initDone;

    assign running = (s_reg.run != irc_pkg::RUN_OFF);

    irc_carrier_gen carrierGen (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .run         (running),
        .divSel      (s_reg.divSel),
        .duty        (s_reg.duty),
        .carrierWave (carrierWave),
        .periodEnd   (periodEnd)
    );

    irc_tau_gen tauGen (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .run       (running),
        .periodEnd (periodEnd),
        .tauSel    (s_reg.tauSel),
        .tauRise   (tauRise)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    always_comb begin
        regIdx    = paddr[17:2];
        hitPrio   = (regIdx == `IRC_IDX_PRIO);
        hitEnable = (regIdx == `IRC_IDX_ENABLE);
        hitFlag   = (regIdx == `IRC_IDX_FLAG);
        hitConfig = (regIdx == `IRC_IDX_CONFIG);
        hitCount  = (regIdx == `IRC_IDX_ICOUNT);
        hitWidth  = (regIdx == `IRC_IDX_WIDTH);
        mapped    = hitPrio | hitEnable | hitFlag | hitConfig | hitCount | hitWidth;
        // Write takes effect only at the edge that completes the access
        wrDone    = psel & penable & s_reg.ready & pwrite & mapped;
        wd        = pwdata[7:0];
        initDone  = (s_reg.initCnt == `IRC_INIT_CYCLES);
        rdMux     = 8'h00;
        if (hitPrio) begin
            rdMux[`IRC_PRIO_LSB +: 2] = s_reg.prio;
        end
        if (hitEnable) begin
            rdMux[`IRC_IRQEN_BIT] = s_reg.irqEn;
            rdMux[`IRC_GENEN_BIT] = s_reg.genEnable;
        end
        if (hitFlag) begin
            rdMux[`IRC_FLAG_BIT]   = s_reg.flag;
            rdMux[`IRC_FORCED_BIT] = s_reg.forced;
        end
        if (hitConfig) begin
            rdMux[`IRC_TAU_LSB +: 2]  = s_reg.tauSel;
            rdMux[`IRC_DIV_BIT]       = s_reg.divSel;
            rdMux[`IRC_DUTY_LSB +: 4] = s_reg.duty;
        end
        // Count register is write-only and reads as zero
        if (hitWidth) begin
            rdMux[`IRC_WIDTH_LSB +: 2] = s_reg.width;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_next = s_reg;
        icDone = 1'b0;

        // No wait state: answer is registered in the setup cycle
        s_next.ready  = psel & ~penable;
        s_next.rdata  = (psel & ~penable & ~pwrite) ? rdMux : 8'h00;
        s_next.slvErr = psel & ~penable & ~mapped;

        // Initialisation window after reset, enable cannot be cleared
        if (!initDone) begin
            s_next.initCnt = s_reg.initCnt + 6'h01;
        end

        // Register writes
        if (wrDone && hitPrio) begin
            s_next.prio = wd[`IRC_PRIO_LSB +: 2];
        end
        if (wrDone && hitEnable) begin
            s_next.irqEn = wd[`IRC_IRQEN_BIT];
            if (wd[`IRC_GENEN_BIT] || initDone) begin
                s_next.genEnable = wd[`IRC_GENEN_BIT];
            end
        end
        if (wrDone && hitFlag) begin
            s_next.forced = wd[`IRC_FORCED_BIT];
            if (wd[`IRC_FLAG_BIT]) begin
                s_next.flag = 1'b0;
            end
        end
        if (wrDone && hitConfig) begin
            s_next.tauSel = wd[`IRC_TAU_LSB +: 2];
            s_next.divSel = wd[`IRC_DIV_BIT];
            s_next.duty   = wd[`IRC_DUTY_LSB +: 4];
        end
        if (wrDone && hitWidth) begin
            s_next.width        = wd[`IRC_WIDTH_LSB +: 2];
            s_next.widthPending = 1'b1;
        end
        if (wrDone && hitCount && s_reg.genEnable) begin
            s_next.icTarget  = wd[`IRC_ICOUNT_LSB +: 4];
            s_next.icPending = 1'b1;
        end

        // Run control: a cleared enable waits for the next tau rise
        unique case (s_reg.run)
            irc_pkg::RUN_OFF: begin
                if (s_reg.genEnable) begin
                    s_next.run = irc_pkg::RUN_ON;
                end
            end
            irc_pkg::RUN_ON: begin
                if (!s_reg.genEnable) begin
                    s_next.run = irc_pkg::RUN_STOPPING;
                end
            end
            irc_pkg::RUN_STOPPING: begin
                if (s_reg.genEnable) begin
                    s_next.run = irc_pkg::RUN_ON;
                end else if (tauRise) begin
                    s_next.run = irc_pkg::RUN_OFF;
                end
            end
        endcase

        // Hard-timer width: loaded at the first tau rise after the write
        if (tauRise) begin
            if (s_reg.widthPending) begin
                s_next.widthLeft    = s_reg.width;
                s_next.widthPending = 1'b0;
            end else if (s_reg.widthLeft != 2'h0) begin
                s_next.widthLeft = s_reg.widthLeft - 2'h1;
            end
        end

        // Interrupt counter: 0xF marks idle, so each write runs it once
        if (tauRise) begin
            if (s_reg.icPending) begin
                s_next.icPending = 1'b0;
                if (s_reg.icTarget == 4'h0) begin
                    icDone         = 1'b1;
                    s_next.icCount = `IRC_IC_IDLE;
                end else begin
                    s_next.icCount = s_reg.icTarget;
                end
            end else if (s_reg.icCount != `IRC_IC_IDLE) begin
                if (s_reg.icCount == 4'h1) begin
                    icDone         = 1'b1;
                    s_next.icCount = `IRC_IC_IDLE;
                end else begin
                    s_next.icCount = s_reg.icCount - 4'h1;
                end
            end
        end

        // Disabled generation drops the width setting at once
        if (!s_reg.genEnable) begin
            s_next.width        = 2'h0;
            s_next.widthPending = 1'b0;
        end
        if (!running) begin
            s_next.widthLeft = 2'h0;
            s_next.icPending = 1'b0;
            s_next.icCount   = `IRC_IC_IDLE;
        end

        // Set wins over a clear in the same cycle; enable is not looked at
        if (icDone) begin
            s_next.flag = 1'b1;
        end

        // Pin is low unless forced or a width count is running
        s_next.carrierOut = running & carrierWave &
                            ((s_reg.forced & s_reg.genEnable) |
                             (s_reg.widthLeft != 2'h0));

        // Level 0 never exceeds any mask, so it never requests
        s_next.irqReq = s_reg.flag & s_reg.irqEn &
                        (s_reg.prio > cpuMaskLevel);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata           = {24'h000000, s_reg.rdata};
    assign pready           = s_reg.ready;
    assign pslverr          = s_reg.slvErr;
    assign carrierOutputPin = s_reg.carrierOut;
    assign irqRequest       = s_reg.irqReq;

endmodule : irc_carrier_top

// [rtl/irc_pkg.sv]
/*
 * Types of the infrared carrier generator: run states and the packed
 * state records of each module.
 * Assumes the constants of irc_regs.svh for widths of the fields.
 */
package irc_pkg;

    typedef enum logic [1:0] {
        RUN_OFF,
        RUN_ON,
        RUN_STOPPING
    } irc_run_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic       wave;
        logic       periodEnd;
    } irc_carrier_state_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic       tauRise;
    } irc_tau_state_t;

    typedef struct packed {
        irc_run_t   run;
        logic       genEnable;
        logic       irqEn;
        logic [1:0] prio;
        logic       flag;
        logic       forced;
        logic [1:0] tauSel;
        logic       divSel;
        logic [3:0] duty;
        logic [3:0] icTarget;
        logic       icPending;
        logic [3:0] icCount;
        logic [1:0] width;
        logic       widthPending;
        logic [1:0] widthLeft;
        logic [5:0] initCnt;
        logic [7:0] rdata;
        logic       ready;
        logic       slvErr;
        logic       carrierOut;
        logic       irqReq;
    } irc_main_state_t;

endpackage : irc_pkg

// [rtl/irc_regs.svh]
/*
 * Register indices, field positions, reset values and counts of the
 * infrared carrier generator.
 * Assumes word-aligned APB access: byte address = 4 * register index.
 */
`ifndef IRC_REGS_SVH
`define IRC_REGS_SVH

// Register indices (byte address is four times the index)
`define IRC_IDX_PRIO        16'hFF21
`define IRC_IDX_ENABLE      16'hFF26
`define IRC_IDX_FLAG        16'hFF27
`define IRC_IDX_CONFIG      16'hFF28
`define IRC_IDX_ICOUNT      16'hFF29
`define IRC_IDX_WIDTH       16'hFF2A

// Field positions
`define IRC_PRIO_LSB        6
`define IRC_IRQEN_BIT       5
`define IRC_GENEN_BIT       4
`define IRC_FLAG_BIT        5
`define IRC_FORCED_BIT      4
`define IRC_TAU_LSB         5
`define IRC_DIV_BIT         4
`define IRC_DUTY_LSB        0
`define IRC_ICOUNT_LSB      4
`define IRC_WIDTH_LSB       6

// Reset values
`define IRC_RST_GENEN       1'b1
`define IRC_RST_IRQEN       1'b0
`define IRC_RST_PRIO        2'h0
`define IRC_RST_DIV         1'b0
`define IRC_RST_DUTY        4'h0
`define IRC_RST_TAU         2'h0
`define IRC_RST_WIDTH       2'h0
`define IRC_IC_IDLE         4'hF

// Counts
`define IRC_DIV64_LAST      7'h3F
`define IRC_DIV96_LAST      7'h5F
`define IRC_DUTY64_MAX      4'h3
`define IRC_DUTY96_LIMIT    4'hC
`define IRC_TAU32_LAST      5'h1F
`define IRC_TAU20_LAST      5'h13
`define IRC_TAU16_LAST      5'h0F
`define IRC_TAU12_LAST      5'h0B
`define IRC_INIT_CYCLES     6'h20

`endif

// [rtl/irc_tau_gen.sv]
/*
 * Reference period divider: counts carrier periods, pulses on each rising
 * edge of the reference waveform.
 * Assumes periodEnd is a one-cycle pulse per carrier period.
 */
`timescale 1ns/10ps
`include "irc_regs.svh"

module irc_tau_gen (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       periodEnd,
    input  wire logic [1:0] tauSel,
    output logic            tauRise
);
    irc_pkg::irc_tau_state_t s_reg, s_next;
    logic [4:0] lastCnt;

    always_comb begin
        unique case (tauSel)
            2'h3: lastCnt = `IRC_TAU32_LAST;
            2'h2: lastCnt = `IRC_TAU20_LAST;
            2'h1: lastCnt = `IRC_TAU16_LAST;
            2'h0: lastCnt = `IRC_TAU12_LAST;
        endcase
        s_next = s_reg;
        s_next.tauRise = 1'b0;
        if (!run) begin
            s_next.cnt = 5'h00;
        end else if (periodEnd) begin
            // Runs on as long as the circuit runs
            if (s_reg.cnt == lastCnt) begin
                s_next.cnt     = 5'h00;
                s_next.tauRise = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tauRise = s_reg.tauRise;

endmodule : irc_tau_gen

// [tb/ir_carrier_generator_test.sv]
/* Self-checking bench of the carrier generator over APB with an LED stage model.
   Assumes one 10 MHz clock and software that follows the required start-up sequence. */
`timescale 1ns/10ps
`include "irc_regs.svh"
module ir_carrier_generator_test;
    logic        ref_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  cpuMaskLevel;
    logic        carrierOutputPin;
    logic        irqRequest;
    logic [15:0] pulseCount;
    logic [15:0] lastHigh;
    logic [15:0] lastPeriod;
    logic [31:0] rd;
    logic        err;
    logic [15:0] p0;
    int          mismatches;
    int          comparisons;
    irc_carrier_top uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpuMaskLevel(cpuMaskLevel), .carrierOutputPin(carrierOutputPin),
        .irqRequest(irqRequest));
    irc_led_model led (.ref_clk(ref_clk), .rst(rst), .carrierOutputPin(carrierOutputPin),
        .pulseCount(pulseCount), .lastHigh(lastHigh), .lastPeriod(lastPeriod));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    // Answer is taken at the completing rising edge, before its updates land
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        @(posedge ref_clk);
        while (pready !== 1'b1 && k < 40) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 40) begin
            mismatches++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : xfer
    task automatic rchk(input logic [15:0] idx, input logic [7:0] e, input string nm);
        xfer(1'b0, idx, 8'h00);
        chk(nm, rd, {24'h000000, e});
    endtask : rchk
    task automatic burst(input logic [7:0] cfg, input int w, input int win, input int np,
                         input int hi, input int per);
        xfer(1'b1, `IRC_IDX_ENABLE, 8'h00);
        repeat (3100) @(posedge ref_clk);
        rchk(`IRC_IDX_WIDTH, 8'h00, "width cleared");
        xfer(1'b1, `IRC_IDX_CONFIG, cfg);
        xfer(1'b1, `IRC_IDX_ENABLE, 8'h10);
        p0 = pulseCount;
        xfer(1'b1, `IRC_IDX_WIDTH, 8'(w << 6));
        repeat (win) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("pulses", 32'(pulseCount - p0), 32'(np));
        if (np > 0) begin
            chk("high time", 32'(lastHigh), 32'(hi));
            chk("period", 32'(lastPeriod), 32'(per));
        end
        $display("test burst %0h done", cfg);
    endtask : burst
    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        cpuMaskLevel = 2'h0;
        mismatches = 0;
        comparisons = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        xfer(1'b1, `IRC_IDX_ENABLE, 8'h00);
        rchk(`IRC_IDX_ENABLE, 8'h10, "enable reset");
        rchk(`IRC_IDX_FLAG, 8'h00, "flag reset");
        rchk(`IRC_IDX_CONFIG, 8'h00, "config reset");
        rchk(`IRC_IDX_PRIO, 8'h00, "prio reset");
        rchk(`IRC_IDX_WIDTH, 8'h00, "width reset");
        xfer(1'b1, `IRC_IDX_CONFIG, 8'h00);
        xfer(1'b1, `IRC_IDX_ICOUNT, 8'h00);
        repeat (1600) @(posedge ref_clk);
        rchk(`IRC_IDX_FLAG, 8'h20, "flag after count 0");
        rchk(`IRC_IDX_ICOUNT, 8'h00, "count read");
        xfer(1'b0, 16'hFF22, 8'h00);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        cpuMaskLevel <= 2'h1;
        xfer(1'b1, `IRC_IDX_PRIO, 8'h80);
        xfer(1'b1, `IRC_IDX_ENABLE, 8'h30);
        @(negedge ref_clk);
        chk("irq raised", {31'h0, irqRequest}, 32'h1);
        @(posedge ref_clk);
        cpuMaskLevel <= 2'h2;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("irq masked", {31'h0, irqRequest}, 32'h0);
        @(posedge ref_clk);
        xfer(1'b1, `IRC_IDX_FLAG, 8'h00);
        rchk(`IRC_IDX_FLAG, 8'h20, "flag kept");
        xfer(1'b1, `IRC_IDX_FLAG, 8'h20);
        rchk(`IRC_IDX_FLAG, 8'h00, "flag cleared");
        xfer(1'b1, `IRC_IDX_ICOUNT, 8'h30);
        repeat (1920) @(posedge ref_clk);
        rchk(`IRC_IDX_FLAG, 8'h00, "flag early");
        repeat (1536) @(posedge ref_clk);
        rchk(`IRC_IDX_FLAG, 8'h20, "flag count 3");
        $display("test interrupt done");
        xfer(1'b1, `IRC_IDX_FLAG, 8'h30);
        repeat (300) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("forced high", 32'(lastHigh), 32'd8);
        chk("forced period", 32'(lastPeriod), 32'd64);
        @(posedge ref_clk);
        xfer(1'b1, `IRC_IDX_FLAG, 8'h00);
        repeat (10) @(posedge ref_clk);
        p0 = pulseCount;
        repeat (300) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("forced off", 32'(pulseCount - p0), 32'd0);
        @(posedge ref_clk);
        $display("test forced done");
        burst(8'h00, 1, 2304, 12, 8, 64);
        burst(8'h2F, 1, 3072, 16, 32, 64);
        burst(8'h42, 1, 3840, 20, 24, 64);
        burst(8'h7B, 1, 9216, 32, 48, 96);
        burst(8'h1C, 1, 3456, 0, 0, 0);
        burst(8'h10, 3, 5760, 36, 4, 96);
        tally_and_finish();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule : ir_carrier_generator_test

// [tb/irc_carrier_chk.sv]
/* Port checker of the carrier generator, bound to its top module.
   Assumes software keeps the configuration steady while the circuit runs. */
`timescale 1ns/10ps
`include "irc_regs.svh"
module irc_carrier_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  cpuMaskLevel,
    input wire logic        carrierOutputPin,
    input wire logic        irqRequest
);
    logic [15:0] idx;
    logic        done;
    logic        mapped;
    logic [1:0]  prioSh;
    logic        irqEnSh;
    logic [6:0]  cfgSh;
    logic [7:0]  highRun;
    logic [7:0]  dutyP1;
    logic [7:0]  hiMax;
    assign idx = paddr[17:2];
    assign done = psel && penable && pready;
    assign mapped = idx inside {`IRC_IDX_PRIO, `IRC_IDX_ENABLE, `IRC_IDX_FLAG,
                                `IRC_IDX_CONFIG, `IRC_IDX_ICOUNT, `IRC_IDX_WIDTH};
    assign dutyP1 = {4'h0, cfgSh[3:0]} + 8'h01;
    // Codes above 3 at divide-by-64 saturate, so the longest high run is 32
    assign hiMax = cfgSh[4] ? (dutyP1 << 2) : ((cfgSh[3:2] != 2'h0) ? 8'h20 : (dutyP1 << 3));
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prioSh <= 2'h0;
            irqEnSh <= 1'b0;
            cfgSh <= 7'h00;
            highRun <= 8'h00;
        end else begin
            if (done && pwrite && idx == `IRC_IDX_PRIO) prioSh <= pwdata[7:6];
            if (done && pwrite && idx == `IRC_IDX_ENABLE) irqEnSh <= pwdata[5];
            if (done && pwrite && idx == `IRC_IDX_CONFIG) cfgSh <= pwdata[6:0];
            highRun <= carrierOutputPin ? highRun + 8'h01 : 8'h00;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("pready held");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_unmapped_error: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
    a_count_reads_zero: assert property (
        pready && !pwrite && idx == `IRC_IDX_ICOUNT |-> prdata == 32'h0) else $error("count read");
    a_config_readback: assert property (
        pready && !pwrite && idx == `IRC_IDX_CONFIG |-> prdata == {25'h0, cfgSh})
        else $error("config readback");
    a_prio_readback: assert property (
        pready && !pwrite && idx == `IRC_IDX_PRIO |-> prdata == {24'h0, prioSh, 6'h0})
        else $error("priority readback");
    a_irq_gated: assert property (
        irqRequest |-> $past(irqEnSh) && ($past(prioSh) > $past(cpuMaskLevel)))
        else $error("request without enable or level");
    a_high_bounded: assert property (carrierOutputPin |-> highRun < hiMax)
        else $error("carrier high too long");
    a_duty_silent: assert property (
        (cfgSh[4] && cfgSh[3:0] >= 4'hC && $stable(cfgSh))[*3] |-> !carrierOutputPin)
        else $error("carrier with blank duty");
    c_irq_raised: cover property (irqRequest);
    c_unmapped: cover property (pslverr);
    c_carrier96: cover property (carrierOutputPin && cfgSh[4]);
endmodule : irc_carrier_chk
bind irc_carrier_top irc_carrier_chk u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpuMaskLevel(cpuMaskLevel),
    .carrierOutputPin(carrierOutputPin), .irqRequest(irqRequest));

// [tb/irc_led_model.sv]
/* Infrared LED drive stage model: counts carrier pulses, measures high time and period.
   Assumes the pin is a registered level sampled on ref_clk. */
`timescale 1ns/10ps
module irc_led_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        carrierOutputPin,
    output logic      [15:0] pulseCount,
    output logic      [15:0] lastHigh,
    output logic      [15:0] lastPeriod
);
    logic        prevPin;
    logic [15:0] highCnt;
    logic [15:0] periodCnt;
    // The LED stage only loads the pin; it drives nothing back
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prevPin <= 1'b0;
            pulseCount <= 16'h0000;
            lastHigh <= 16'h0000;
            lastPeriod <= 16'h0000;
            highCnt <= 16'h0000;
            periodCnt <= 16'h0000;
        end else begin
            prevPin <= carrierOutputPin;
            periodCnt <= periodCnt + 16'h0001;
            if (carrierOutputPin) highCnt <= highCnt + 16'h0001;
            if (!carrierOutputPin && prevPin) lastHigh <= highCnt;
            if (carrierOutputPin && !prevPin) begin
                pulseCount <= pulseCount + 16'h0001;
                lastPeriod <= periodCnt;
                periodCnt <= 16'h0001;
                highCnt <= 16'h0001;
            end
        end
    end
endmodule : irc_led_model
